// ### shared/trigger_packet_pkg.sv
// Constants, register map and packet layout for the trigger packet FIFO
// ============================================================
// How it works
// - Buffer fed only in streaming transfer mode
// - One packet per trigger while buffering enabled
// - After packet stored, reset all channel triggers
// - Buffering disabled: trigger stores nothing
// - Packet is twenty 16-bit words
// - Words 0-2 hold fixed header constants
// - Word 3: zeros, estop bit, input port
// - Words 4-5: timestamp low then high
// - Words 6-13: per channel count or PWM
// - Even word low count/on-time, odd high/period
// - Words 14-15 pack channel status fields
// - Words 16-19: 12-bit converter readings, zero-extended
// - Enable register bit 8 switches buffering
// - Every merged trigger rising edge while the sequencer is idle, buffering and streaming are on, there is room and no flush that cycle stores one packet
// - Full buffer discards newly triggered packet
// - Buffer holds 32MB of storage
// - Channel retriggers only after status cleared
// - After storing, clear channel status automatically
// - Status register shows empty and full flags
// - Writing clear bit 0 then 1 flushes
package trigger_packet_pkg;

  // ============================================================
  // Packet shape
  localparam int PACKET_WORDS = 20;
  localparam int WORD_W = 16;
  localparam int IDX_W = 5;
  localparam logic [IDX_W-1:0] LAST_WORD_IDX = 5'h13;
  localparam logic [WORD_W-1:0] HEADER_WORD0 = 16'h2211;
  localparam logic [WORD_W-1:0] HEADER_WORD1 = 16'h4433;
  localparam logic [WORD_W-1:0] HEADER_WORD2 = 16'h6655;

  // ============================================================
  // Storage size: 32MB of 16-bit words
  localparam longint FIFO_BYTES = 64'd33554432;
  localparam int FIFO_DEPTH = int'(FIFO_BYTES / 2);
  localparam int PTR_W = 24;
  localparam int CNT_W = 25;
  localparam logic [CNT_W-1:0] DEPTH_COUNT = 25'h1000000;
  localparam logic [CNT_W-1:0] ROOM_LIMIT = 25'h0ffffec;

  // ============================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] REG_IDX_ENABLE = 8'h25;
  localparam logic [7:0] REG_IDX_STATE = 8'h26;
  localparam logic [7:0] REG_IDX_DROPPED = 8'h3d;
  localparam logic [7:0] REG_IDX_READ = 8'h3e;
  localparam logic [7:0] REG_IDX_MODE = 8'h3f;
  localparam logic [11:0] ADDR_ENABLE = {2'b00, REG_IDX_ENABLE, 2'b00};
  localparam logic [11:0] ADDR_STATE = {2'b00, REG_IDX_STATE, 2'b00};
  localparam logic [11:0] ADDR_DROPPED = {2'b00, REG_IDX_DROPPED, 2'b00};
  localparam logic [11:0] ADDR_READ = {2'b00, REG_IDX_READ, 2'b00};
  localparam logic [11:0] ADDR_MODE = {2'b00, REG_IDX_MODE, 2'b00};

  // ============================================================
  // Field positions and reset values
  localparam int ENABLE_BIT = 8;
  localparam int CLEAR_BIT = 0;
  localparam int FULL_BIT = 8;
  localparam int EMPTY_BIT = 9;
  localparam int STREAM_BIT = 0;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic CLEAR_RST = 1'b0;
  localparam logic STREAM_RST = 1'b0;
  localparam logic [15:0] DROPPED_RST = 16'h0000;

  // ============================================================
  // Capture sequencer states
  typedef enum logic {CAPTURE_IDLE, CAPTURE_WRITE} capture_state_t;

endpackage

// ### design/packet_word_store.sv
// Word FIFO built from an indexed flip-flop array
`timescale 1ns/100ps
`default_nettype none
module packet_word_store
  import trigger_packet_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic flush,
  input wire logic wrValid,
  input wire logic [WORD_W-1:0] wrData,
  input wire logic rdTake,
  output logic [WORD_W-1:0] rdData,
  output logic [CNT_W-1:0] fillCount
);

  // ============================================================
  // Storage and pointers
  logic [WORD_W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtr_ff;
  logic [PTR_W-1:0] rdPtr_ff;
  logic [CNT_W-1:0] count_ff;
  logic doWrite;
  logic doRead;

  // Refuse a write when full and a read when empty
  assign doWrite = wrValid && (count_ff != DEPTH_COUNT);
  assign doRead = rdTake && (count_ff != '0);

  // Words land at the write pointer; no reset on the array itself
  always_ff @(posedge mclk) begin
    if (doWrite && !flush) begin
      mem[wrPtr_ff] <= wrData;
    end
  end

  // Pointers wrap naturally, depth is a power of two
  always_ff @(posedge mclk) begin
    if (reset || flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_ff <= wrPtr_ff + PTR_W'(1);
      end
      if (doRead) begin
        rdPtr_ff <= rdPtr_ff + PTR_W'(1);
      end
    end
  end

  // Fill level, simultaneous read and write cancel out
  always_ff @(posedge mclk) begin
    if (reset || flush) begin
      count_ff <= '0;
    end else if (doWrite && !doRead) begin
      count_ff <= count_ff + CNT_W'(1);
    end else if (doRead && !doWrite) begin
      count_ff <= count_ff - CNT_W'(1);
    end
  end

  assign rdData = mem[rdPtr_ff];
  assign fillCount = count_ff;

endmodule
`default_nettype wire

// ### design/trigger_packet_fifo.sv
// Trigger packet capture FIFO with APB register slave
`timescale 1ns/100ps
`default_nettype none
module trigger_packet_fifo
  import trigger_packet_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Merged trigger pulse from the encoder channels
  input wire logic combinedTrigger,
  // Pins, synchronised before use
  input wire logic estopPin,
  input wire logic [7:0] inputPortPin,
  // Same-clock acquisition data
  input wire logic [31:0] timeStamp,
  input wire logic [23:0] count0,
  input wire logic [23:0] count1,
  input wire logic [23:0] count2,
  input wire logic [23:0] count3,
  input wire logic pwmMode0,
  input wire logic pwmMode1,
  input wire logic pwmMode2,
  input wire logic pwmMode3,
  input wire logic [15:0] pulseWidthInputZero,
  input wire logic [15:0] pulseWidthInputOne,
  input wire logic [15:0] pulseWidthInputTwo,
  input wire logic [15:0] pulseWidthInputThree,
  input wire logic [15:0] period0,
  input wire logic [15:0] period1,
  input wire logic [15:0] period2,
  input wire logic [15:0] period3,
  input wire logic [31:0] channelZeroStateWord,
  input wire logic [31:0] channelOneStateWord,
  input wire logic [31:0] channelTwoStateWord,
  input wire logic [31:0] channelThreeStateWord,
  input wire logic [11:0] adc0,
  input wire logic [11:0] adc1,
  input wire logic [11:0] adc2,
  input wire logic [11:0] adc3,
  // One-cycle pulses after a packet is stored
  output logic triggerReset,
  output logic statusClear
);

  // ============================================================
  // Helper functions

  // Even word of a channel pair: low count bits or PWM on-time
  function automatic logic [15:0] lowWord(
    input logic pwm,
    input logic [23:0] cnt,
    input logic [15:0] onTime
  );
    return pwm ? onTime : cnt[15:0];
  endfunction

  // Odd word of a channel pair: zero-padded high count or period
  function automatic logic [15:0] highWord(
    input logic pwm,
    input logic [23:0] cnt,
    input logic [15:0] per
  );
    return pwm ? per : {8'h00, cnt[23:16]};
  endfunction

  // Status fields of one channel: bit 23 then bits 13 down to 7
  function automatic logic [7:0] statusField(input logic [31:0] st);
    return {st[23], st[13:7]};
  endfunction

  // ============================================================
  // Pin synchronisers
  logic estopMeta_ff;
  logic estopSync_ff;
  logic [7:0] portMeta_ff;
  logic [7:0] portSync_ff;

  // Two flops each; only the second stage feeds the packet
  always_ff @(posedge mclk) begin
    if (reset) begin
      estopMeta_ff <= 1'b0;
      estopSync_ff <= 1'b0;
      portMeta_ff <= 8'h00;
      portSync_ff <= 8'h00;
    end else begin
      estopMeta_ff <= estopPin;
      estopSync_ff <= estopMeta_ff;
      portMeta_ff <= inputPortPin;
      portSync_ff <= portMeta_ff;
    end
  end

  // ============================================================
  // Register state
  logic enable_ff;
  logic clearBit_ff;
  logic streamMode_ff;
  logic [15:0] dropped_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic readHit_ff;

  // ============================================================
  // FIFO wiring
  logic flush;
  logic wrValid;
  logic [WORD_W-1:0] wrData;
  logic rdTake;
  logic [WORD_W-1:0] rdData;
  logic [CNT_W-1:0] fillCount;
  logic fifoEmpty;
  logic fifoFull;

  packet_word_store u_store (
    .mclk(mclk),
    .reset(reset),
    .flush(flush),
    .wrValid(wrValid),
    .wrData(wrData),
    .rdTake(rdTake),
    .rdData(rdData),
    .fillCount(fillCount)
  );

  // Full means no room for one more whole packet
  assign fifoEmpty = (fillCount == '0);
  assign fifoFull = (fillCount > ROOM_LIMIT);

  // ============================================================
  // Live packet assembly
  logic [WORD_W-1:0] liveWord [PACKET_WORDS];

  // Fixed layout of the twenty words
  always_comb begin
    liveWord[0] = HEADER_WORD0;
    liveWord[1] = HEADER_WORD1;
    liveWord[2] = HEADER_WORD2;
    liveWord[3] = {7'h00, estopSync_ff, portSync_ff};
    liveWord[4] = timeStamp[15:0];
    liveWord[5] = timeStamp[31:16];
    liveWord[6] = lowWord(pwmMode0, count0, pulseWidthInputZero);
    liveWord[7] = highWord(pwmMode0, count0, period0);
    liveWord[8] = lowWord(pwmMode1, count1, pulseWidthInputOne);
    liveWord[9] = highWord(pwmMode1, count1, period1);
    liveWord[10] = lowWord(pwmMode2, count2, pulseWidthInputTwo);
    liveWord[11] = highWord(pwmMode2, count2, period2);
    liveWord[12] = lowWord(pwmMode3, count3, pulseWidthInputThree);
    liveWord[13] = highWord(pwmMode3, count3, period3);
    liveWord[14] = {statusField(channelOneStateWord),
                    statusField(channelZeroStateWord)};
    liveWord[15] = {statusField(channelThreeStateWord),
                    statusField(channelTwoStateWord)};
    liveWord[16] = {4'h0, adc0};
    liveWord[17] = {4'h0, adc1};
    liveWord[18] = {4'h0, adc2};
    liveWord[19] = {4'h0, adc3};
  end

  // ============================================================
  // Trigger detection and capture decision
  logic trigPrev_ff;
  logic trigEdge;
  logic captureOk;
  logic captureGo;
  logic captureDrop;
  capture_state_t state_ff;

  // Rising edge, so a held trigger level counts only once
  always_ff @(posedge mclk) begin
    if (reset) begin
      trigPrev_ff <= 1'b0;
    end else begin
      trigPrev_ff <= combinedTrigger;
    end
  end

  assign trigEdge = combinedTrigger && !trigPrev_ff;

  // Only streaming mode with buffering on feeds the store
  assign captureOk = streamMode_ff && enable_ff;
  // Room for a whole packet is checked before any word is written
  assign captureGo = trigEdge && captureOk && !fifoFull
                     && (state_ff == CAPTURE_IDLE) && !flush;
  assign captureDrop = trigEdge && captureOk && fifoFull;

  // ============================================================
  // Packet sequencer
  logic [WORD_W-1:0] snapshot_ff [PACKET_WORDS];
  logic [IDX_W-1:0] wordIdx_ff;
  logic triggerReset_ff;
  logic statusClear_ff;
  logic lastWord;

  assign lastWord = (wordIdx_ff == LAST_WORD_IDX);

  // Freeze all fields at the trigger so the packet is coherent
  always_ff @(posedge mclk) begin
    if (captureGo) begin
      for (int i = 0; i < PACKET_WORDS; i++) begin
        snapshot_ff[i] <= liveWord[i];
      end
    end
  end

  // One word per cycle, ascending, nothing interleaved
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= CAPTURE_IDLE;
      wordIdx_ff <= '0;
    end else begin
      case (state_ff)
        CAPTURE_IDLE: begin
          wordIdx_ff <= '0;
          if (captureGo) begin
            state_ff <= CAPTURE_WRITE;
          end
        end
        CAPTURE_WRITE: begin
          // A flush mid-packet abandons the rest of it
          if (flush || lastWord) begin
            state_ff <= CAPTURE_IDLE;
            wordIdx_ff <= '0;
          end else begin
            wordIdx_ff <= wordIdx_ff + IDX_W'(1);
          end
        end
        default: begin
          state_ff <= CAPTURE_IDLE;
          wordIdx_ff <= '0;
        end
      endcase
    end
  end

  assign wrValid = (state_ff == CAPTURE_WRITE);
  assign wrData = snapshot_ff[wordIdx_ff];

  // Reset triggers and clear channel status once the packet is in
  always_ff @(posedge mclk) begin
    if (reset) begin
      triggerReset_ff <= 1'b0;
      statusClear_ff <= 1'b0;
    end else begin
      triggerReset_ff <= wrValid && lastWord && !flush;
      statusClear_ff <= wrValid && lastWord && !flush;
    end
  end

  assign triggerReset = triggerReset_ff;
  assign statusClear = statusClear_ff;

  // Count packets lost to a full store, saturating
  always_ff @(posedge mclk) begin
    if (reset) begin
      dropped_ff <= DROPPED_RST;
    end else if (captureDrop && dropped_ff != 16'hffff) begin
      dropped_ff <= dropped_ff + 16'h0001;
    end
  end

  // ============================================================
  // APB slave: answer on the second access cycle
  logic access;
  logic done;
  logic wrDone;
  logic mapped;

  assign access = psel && penable;
  assign done = access && pready_ff;
  assign wrDone = done && pwrite;
  assign mapped = (paddr == ADDR_ENABLE) || (paddr == ADDR_STATE)
                  || (paddr == ADDR_DROPPED) || (paddr == ADDR_READ)
                  || (paddr == ADDR_MODE);

  // Pop only the word handed out in the first access cycle, so a word
  // landing between the two access edges is never lost
  assign rdTake = done && readHit_ff;
  // Flush only on a 0 to 1 step of the clear bit
  assign flush = wrDone && (paddr == ADDR_STATE)
                 && pwdata[CLEAR_BIT] && !clearBit_ff;

  // Handshake and read data, one wait state for every access
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      readHit_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= access && !pready_ff;
      if (access && !pready_ff) begin
        pslverr_ff <= !mapped;
        readHit_ff <= !pwrite && (paddr == ADDR_READ) && !fifoEmpty;
        prdata_ff <= 32'h00000000;
        if (!pwrite) begin
          case (paddr)
            ADDR_ENABLE: prdata_ff[ENABLE_BIT] <= enable_ff;
            ADDR_STATE: begin
              prdata_ff[EMPTY_BIT] <= fifoEmpty;
              prdata_ff[FULL_BIT] <= fifoFull;
              prdata_ff[CLEAR_BIT] <= clearBit_ff;
            end
            ADDR_DROPPED: prdata_ff[15:0] <= dropped_ff;
            // Empty store reads as zero rather than stale data
            ADDR_READ: prdata_ff[15:0] <= fifoEmpty ? 16'h0000 : rdData;
            ADDR_MODE: prdata_ff[STREAM_BIT] <= streamMode_ff;
            default: prdata_ff <= 32'h00000000;
          endcase
        end
      end else begin
        pslverr_ff <= 1'b0;
        readHit_ff <= 1'b0;
      end
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // Writable control bits, taken only at the completing edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_ff <= ENABLE_RST;
      clearBit_ff <= CLEAR_RST;
      streamMode_ff <= STREAM_RST;
    end else if (wrDone) begin
      if (paddr == ADDR_ENABLE) begin
        enable_ff <= pwdata[ENABLE_BIT];
      end
      if (paddr == ADDR_STATE) begin
        clearBit_ff <= pwdata[CLEAR_BIT];
      end
      if (paddr == ADDR_MODE) begin
        streamMode_ff <= pwdata[STREAM_BIT];
      end
    end
  end

endmodule
`default_nettype wire

// ### sim/trigger_packet_fifo_sva.sv
// Port checker for the trigger packet FIFO
`timescale 1ns/100ps
`default_nettype none
module trigger_packet_fifo_sva
  import trigger_packet_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic combinedTrigger,
  input wire logic triggerReset,
  input wire logic statusClear
);
  // ============================================================
  // Shadow of enable and streaming bits
  logic enable_ff;
  logic stream_ff;
  logic takeWr;
  assign takeWr = psel && penable && pready && pwrite && !pslverr;
  // Refused writes must not move the shadow
  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_ff <= 1'b0;
    end else if (takeWr && paddr == ADDR_ENABLE) begin
      enable_ff <= pwdata[ENABLE_BIT];
    end
  end
  // Streaming bit kept apart from the enable
  always_ff @(posedge mclk) begin
    if (reset) begin
      stream_ff <= 1'b0;
    end else if (takeWr && paddr == ADDR_MODE) begin
      stream_ff <= pwdata[STREAM_BIT];
    end
  end
  // ============================================================
  // Properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  property p_one_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no single wait");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  property p_err_ready;
    pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("bad error answer");
  property p_unmapped;
    psel && penable && pready && paddr == 12'h000 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  property p_pair;
    triggerReset || statusClear |-> triggerReset && statusClear;
  endproperty
  a_pair: assert property (p_pair) else $error("pulses split");
  property p_pulse_one;
    triggerReset |=> !triggerReset;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse long");
  property p_store;
    $rose(combinedTrigger) && enable_ff && stream_ff |-> ##[20:23] triggerReset;
  endproperty
  a_store: assert property (p_store) else $error("packet not done");
  property p_off;
    $rose(combinedTrigger) && !(enable_ff && stream_ff)
      |-> ##20 !triggerReset [*4];
  endproperty
  a_off: assert property (p_off) else $error("stored while off");
endmodule
bind trigger_packet_fifo trigger_packet_fifo_sva trigger_packet_fifo_sva_inst (
  .mclk(mclk),
  .reset(reset),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .combinedTrigger(combinedTrigger),
  .triggerReset(triggerReset),
  .statusClear(statusClear)
);
`default_nettype wire

// ### sim/encoder_trigger_model.sv
// Encoder channel side: merged trigger with pending status
`timescale 1ns/100ps
`default_nettype none
module encoder_trigger_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic fire,
  input wire logic hostClear,
  input wire logic statusClear,
  output logic combinedTrigger
);
  logic pending_ff;
  // Pending status blocks retrigger, so a burst gives one pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      pending_ff <= 1'b0;
      combinedTrigger <= 1'b0;
    end else begin
      combinedTrigger <= fire && !pending_ff;
      if (statusClear || hostClear) begin
        pending_ff <= 1'b0;
      end else if (fire) begin
        pending_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/trigger_packet_fifo_test.sv
// Register-level testbench for the trigger packet FIFO
`timescale 1ns/100ps
`default_nettype none
module trigger_packet_fifo_test;
  import trigger_packet_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic pready, pslverr, combinedTrigger, triggerReset, statusClear;
  logic fire = 1'b0, hostClear = 1'b0, pwm = 1'b0, estop = 1'b1;
  logic [7:0] port = 8'h5a;
  logic [31:0] ts = 32'h89abcdef;
  logic [23:0] cnt [4] = '{24'ha10001, 24'hb20002, 24'hc30003, 24'hd40004};
  logic [15:0] onT [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
  logic [15:0] per [4] = '{16'h9001, 16'h9002, 16'h9003, 16'h9004};
  logic [31:0] st [4] = '{32'h00801f80, 32'h00000080, 32'h00802a00, 32'h0};
  logic [11:0] adc [4] = '{12'h123, 12'h456, 12'h789, 12'habc};
  int failCount = 0;
  int testsRun = 0;

  // ============================================================
  // Clock, design and channel model
  always #10 mclk = ~mclk;
  trigger_packet_fifo trigger_packet_fifo_inst (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .combinedTrigger(combinedTrigger), .estopPin(estop),
    .inputPortPin(port), .timeStamp(ts), .count0(cnt[0]),
    .count1(cnt[1]), .count2(cnt[2]), .count3(cnt[3]), .pwmMode0(pwm),
    .pwmMode1(pwm), .pwmMode2(pwm), .pwmMode3(pwm),
    .pulseWidthInputZero(onT[0]), .pulseWidthInputOne(onT[1]),
    .pulseWidthInputTwo(onT[2]), .pulseWidthInputThree(onT[3]),
    .period0(per[0]), .period1(per[1]), .period2(per[2]),
    .period3(per[3]), .channelZeroStateWord(st[0]),
    .channelOneStateWord(st[1]), .channelTwoStateWord(st[2]),
    .channelThreeStateWord(st[3]), .adc0(adc[0]), .adc1(adc[1]),
    .adc2(adc[2]), .adc3(adc[3]), .triggerReset(triggerReset),
    .statusClear(statusClear));
  encoder_trigger_model encoder_trigger_model_inst (.mclk(mclk),
    .reset(reset), .fire(fire), .hostClear(hostClear),
    .statusClear(statusClear), .combinedTrigger(combinedTrigger));

  // ============================================================
  // Expected packet word, worked out from the field layout
  function automatic logic [15:0] expWord(input int i, input logic pm);
    int ch;
    ch = (i - 6) / 2;
    if (i == 0) return 16'h2211;
    if (i == 1) return 16'h4433;
    if (i == 2) return 16'h6655;
    if (i == 3) return {7'h00, estop, port};
    if (i == 4) return ts[15:0];
    if (i == 5) return ts[31:16];
    if (i < 14 && i % 2 == 0) return pm ? onT[ch] : cnt[ch][15:0];
    if (i < 14) return pm ? per[ch] : {8'h00, cnt[ch][23:16]};
    if (i == 14) return {st[1][23], st[1][13:7], st[0][23], st[0][13:7]};
    if (i == 15) return {st[3][23], st[3][13:7], st[2][23], st[2][13:7]};
    return {4'h0, adc[i-16]};
  endfunction

  // ============================================================
  // Bus cycle, compare and trigger tasks
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Master waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdChk(input string name, input logic [11:0] a,
                       input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r & mask);
    chk({name, " error"}, 32'h0, {31'h0, e});
  endtask
  // Fires n times two cycles apart, then lets any packet finish
  task automatic trig(input int n);
    repeat (n) begin
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
    end
    repeat (25) @(posedge mclk);
  endtask
  task automatic clearPending();
    @(posedge mclk);
    hostClear <= 1'b1;
    @(posedge mclk);
    hostClear <= 1'b0;
  endtask
  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ============================================================
  // Watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    #(20 * 20000);
    failCount++;
    stopTest();
  end

  // ============================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rdChk("state", ADDR_STATE, 32'h200, 32'hffffffff);
    rdChk("enable", ADDR_ENABLE, 32'h0, 32'hffffffff);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(ADDR_ENABLE, 32'h100);
    rdChk("enable", ADDR_ENABLE, 32'h100, 32'h100);
    trig(1);
    rdChk("state no stream", ADDR_STATE, 32'h200, 32'h300);
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_ENABLE, 32'h0);
    clearPending();
    trig(1);
    rdChk("state disabled", ADDR_STATE, 32'h200, 32'h300);
    wr(ADDR_ENABLE, 32'h100);
    clearPending();
    trig(2);
    rdChk("state one", ADDR_STATE, 32'h0, 32'h300);
    @(posedge mclk);
    pwm <= 1'b1;
    trig(1);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 20; i++) begin
        rdChk("word", ADDR_READ, {16'h0, expWord(i, p == 1)}, 32'hffff);
      end
    end
    rdChk("state drained", ADDR_STATE, 32'h200, 32'h300);
    rdChk("empty read", ADDR_READ, 32'h0, 32'hffff);
    rdChk("dropped", ADDR_DROPPED, 32'h0, 32'hffff);
    trig(1);
    rdChk("state third", ADDR_STATE, 32'h0, 32'h300);
    wr(ADDR_ENABLE, 32'h0);
    wr(ADDR_STATE, 32'h0);
    wr(ADDR_STATE, 32'h1);
    rdChk("state flushed", ADDR_STATE, 32'h201, 32'h301);
    rdChk("flushed read", ADDR_READ, 32'h0, 32'hffff);
    stopTest();
  end
endmodule
`default_nettype wire
